// ===== rtl/ecd_diag.sv
// Purpose: Counter wrap flags, open-circuit and supply diagnostics
// Assumes: Counts come from same-clock counter logic; pins are async
// Notes:   Analog comparators deliver the low-differential decision
//
// Overview of operation
// - Underflow flag set on reset-to-limit wrap
// - Underflow clears below two thirds of range
// - Overflow flag set on limit-to-reset wrap
// - Overflow clears above one third of range
// - Default limit all ones, reset zero
// - Faults detected only in differential mode
// - Shorted pair reads as low differential
// - Separate detection enable per track
// - Channel one index zero, two index one
// - Group open flag while any track faulty
// - Data invalid while open-circuit fault present
// - Per-track error flag follows that fault
// - Track A fault logs message with channel
// - Track LED green on level, red fault
// - Supply-failure flag true while supply missing
// - Missing supply logs message, LED off
// - Messages carry ID, type; debug message
// - Single broken wire may flag intermittently
`timescale 1ns/1ps
module ecd_diag #(
    parameter int CNT_W = 32,
    parameter int NCH   = 2
) (
    // Clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   sys_rst_i,
    // Register port
    input  wire logic [7:0]             addr_i,
    input  wire logic [31:0]            wdata_i,
    input  wire logic                   wr_i,
    input  wire logic                   rd_i,
    output logic      [31:0]            rdata_o,
    // Counter values, same clock
    input  wire logic [NCH-1:0][CNT_W-1:0] count_i,
    // Encoder pins
    input  wire logic [NCH-1:0][2:0]    diff_low_i,
    input  wire logic [NCH-1:0][2:0]    track_i,
    input  wire logic [NCH-1:0]         supply_ok_i,
    // Process data flags
    output logic      [NCH-1:0]         underflow_o,
    output logic      [NCH-1:0]         overflow_o,
    output logic      [NCH-1:0]         open_circuit_o,
    output logic      [NCH-1:0]         data_invalid_flag_o,
    output logic      [NCH-1:0][2:0]    track_error_o,
    output logic      [NCH-1:0]         supply_fail_o,
    // Indicators
    output logic      [NCH-1:0][2:0][1:0] track_indicator_o,
    output logic      [NCH-1:0]         supply_led_o,
    // Diagnostic text log
    output logic                        diag_valid_o,
    output ecd_pkg::ecd_msg_t           diagnostic_text_log_o
);
    // ****************************************************************
    // Checks and helpers
    // ****************************************************************
    if (NCH != 2) begin : g_bad_nch
        $error("ecd_diag serves exactly two channels");
    end
    if (CNT_W < 4 || CNT_W > 32) begin : g_bad_cnt_w
        $error("CNT_W out of range");
    end

    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] off);
        hit = (a == off);
    endfunction

    function automatic logic [CNT_W-1:0] third(input logic [CNT_W-1:0] v);
        third = v / CNT_W'(3);
    endfunction

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    logic [NCH-1:0][2:0] low_f;
    logic [NCH-1:0][2:0] trk_f;
    logic [NCH-1:0]      sup_lost_f;
    // Synchronised inverted so reset reads as present, no false alarm
    wire  [NCH-1:0]      sup_f = ~sup_lost_f;

    ecd_sync #(.W(NCH * 7)) u_sync (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .d_i       ({diff_low_i, track_i, ~supply_ok_i}),
        .q_o       ({low_f, trk_f, sup_lost_f})
    );

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [NCH-1:0][3:0]       cfg;
    logic [NCH-1:0][CNT_W-1:0] lim;
    logic [NCH-1:0][CNT_W-1:0] rstv;
    logic [NCH-1:0][CNT_W-1:0] cnt_q;
    logic [NCH-1:0]            primed;
    logic [15:0]               dbg0;
    logic [15:0]               dbg1;
    logic [NCH-1:0][7:0]       status;
    wire                       wr_dbg0 = wr_i & hit(addr_i, ecd_pkg::ECD_OFF_DBG0);
    wire                       wr_dbg1 = wr_i & hit(addr_i, ecd_pkg::ECD_OFF_DBG1);
    wire                       wr_dbg2 = wr_i & hit(addr_i, ecd_pkg::ECD_OFF_DBG2);

    logic [NCH-1:0]            ev_trk_a;
    logic [NCH-1:0]            ev_sup;
    logic [NCH-1:0][31:0]      rd_ch;
    logic [NCH-1:0]            rd_hit;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            dbg0 <= 16'h0000;
            dbg1 <= 16'h0000;
        end else begin
            if (wr_dbg0) dbg0 <= wdata_i[15:0];
            if (wr_dbg1) dbg1 <= wdata_i[15:0];
        end
    end

    // ****************************************************************
    // Per-channel logic
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            // Channel g at index g of each stride pattern
            localparam logic [7:0] BASE = 8'(g * 16);
            wire wr_cfg = wr_i & hit(addr_i, BASE + ecd_pkg::ECD_OFF_CFG);
            wire wr_lim = wr_i & hit(addr_i, BASE + ecd_pkg::ECD_OFF_LIMIT);
            wire wr_rst = wr_i & hit(addr_i, BASE + ecd_pkg::ECD_OFF_RESET);
            // Thresholds assume limit above reset value
            wire [CNT_W-1:0] range = lim[g] - rstv[g];
            wire [CNT_W-1:0] th1   = rstv[g] + third(range);
            wire [CNT_W-1:0] th2   = rstv[g] + CNT_W'(third(range) << 1);
            wire wrap_dn = primed[g] & (cnt_q[g] == rstv[g])
                           & (count_i[g] == lim[g]);
            wire wrap_up = primed[g] & (cnt_q[g] == lim[g])
                           & (count_i[g] == rstv[g]);
            // Set beats clear so a wrap is never lost
            wire next_unf = wrap_dn
                          | (underflow_o[g] & ~(count_i[g] < th2));
            wire next_ovf = wrap_up
                          | (overflow_o[g] & ~(count_i[g] > th1));
            // Shorted pair and broken wire both look like low voltage
            wire [2:0] fault = {3{cfg[g][ecd_pkg::ECD_CFG_DIFF]}}
                               & cfg[g][2:0] & low_f[g];
            // No latching: a marginal single break may flicker
            wire next_open = |fault;
            logic [2:0][1:0] next_led;
            for (genvar t = 0; t < 3; t++) begin : g_trk
                assign next_led[t] = fault[t] ? ecd_pkg::ECD_LED_RED
                                   : trk_f[g][t] ? ecd_pkg::ECD_LED_GREEN
                                   : ecd_pkg::ECD_LED_OFF;
            end
            assign ev_trk_a[g] = fault[0] & ~track_error_o[g][0];
            assign ev_sup[g]   = ~sup_f[g] & ~supply_fail_o[g];
            assign status[g] = {supply_fail_o[g], track_error_o[g],
                                data_invalid_flag_o[g], open_circuit_o[g],
                                overflow_o[g], underflow_o[g]};
            assign rd_hit[g] = hit(addr_i, BASE + ecd_pkg::ECD_OFF_CFG)
                             | hit(addr_i, BASE + ecd_pkg::ECD_OFF_LIMIT)
                             | hit(addr_i, BASE + ecd_pkg::ECD_OFF_RESET)
                             | hit(addr_i, BASE + ecd_pkg::ECD_OFF_STATUS);
            assign rd_ch[g] =
                hit(addr_i, BASE + ecd_pkg::ECD_OFF_CFG) ? 32'(cfg[g])
              : hit(addr_i, BASE + ecd_pkg::ECD_OFF_LIMIT) ? 32'(lim[g])
              : hit(addr_i, BASE + ecd_pkg::ECD_OFF_RESET) ? 32'(rstv[g])
              : hit(addr_i, BASE + ecd_pkg::ECD_OFF_STATUS) ? 32'(status[g])
              : 32'h0000_0000;

            // Configuration, defaults limit all ones and reset zero
            always_ff @(posedge clk_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    cfg[g]  <= ecd_pkg::ECD_CFG_RST;
                    lim[g]  <= '1;
                    rstv[g] <= '0;
                end else begin
                    if (wr_cfg) cfg[g] <= wdata_i[3:0];
                    if (wr_lim) lim[g] <= wdata_i[CNT_W-1:0];
                    if (wr_rst) rstv[g] <= wdata_i[CNT_W-1:0];
                end
            end

            // Flags evaluated every cycle
            always_ff @(posedge clk_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    cnt_q[g]               <= '0;
                    primed[g]              <= 1'b0;
                    underflow_o[g]         <= 1'b0;
                    overflow_o[g]          <= 1'b0;
                    track_error_o[g]       <= 3'h0;
                    open_circuit_o[g]      <= 1'b0;
                    data_invalid_flag_o[g] <= 1'b0;
                    supply_fail_o[g]       <= 1'b0;
                    supply_led_o[g]        <= 1'b0;
                    track_indicator_o[g]   <= '0;
                end else begin
                    cnt_q[g]               <= count_i[g];
                    primed[g]              <= 1'b1;
                    underflow_o[g]         <= next_unf;
                    overflow_o[g]          <= next_ovf;
                    track_error_o[g]       <= fault;
                    open_circuit_o[g]      <= next_open;
                    data_invalid_flag_o[g] <= next_open;
                    supply_fail_o[g]       <= ~sup_f[g];
                    supply_led_o[g]        <= sup_f[g];
                    track_indicator_o[g]   <= next_led;
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Read port, data one cycle after the strobe
    // ****************************************************************
    wire [31:0] next_rdata =
        ~rd_i ? 32'h0000_0000
      : rd_hit[0] ? rd_ch[0]
      : rd_hit[1] ? rd_ch[1]
      : hit(addr_i, ecd_pkg::ECD_OFF_DBG0) ? {16'h0000, dbg0}
      : hit(addr_i, ecd_pkg::ECD_OFF_DBG1) ? {16'h0000, dbg1}
      : 32'h0000_0000;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) rdata_o <= 32'h0000_0000;
        else rdata_o <= next_rdata;
    end

    // ****************************************************************
    // Diagnostic message queue
    // ****************************************************************
    // Events that collide wait as pending bits, one message per cycle
    logic [ecd_pkg::ECD_NSRC-1:0] pend;
    logic [15:0]                  dbg2;
    wire  [ecd_pkg::ECD_NSRC-1:0] ev = {wr_dbg2, ev_sup, ev_trk_a};
    wire  [ecd_pkg::ECD_NSRC-1:0] grant = pend & (~pend + 5'h01);
    wire  [ecd_pkg::ECD_NSRC-1:0] next_pend = (pend & ~grant) | ev;
    ecd_pkg::ecd_msg_t            next_msg;

    assign next_msg.text_id = grant[ecd_pkg::ECD_SRC_DBG]
                            ? ecd_pkg::ECD_ID_DEBUG
                            : (|grant[3:2]) ? ecd_pkg::ECD_ID_SUPPLY
                            : ecd_pkg::ECD_ID_TRACK_A;
    assign next_msg.mtype = grant[ecd_pkg::ECD_SRC_DBG]
                          ? ecd_pkg::ECD_T_INFO : ecd_pkg::ECD_T_ERROR;
    assign next_msg.chan = grant[1] | grant[3];
    assign next_msg.p0 = grant[ecd_pkg::ECD_SRC_DBG] ? dbg0 : 16'h0000;
    assign next_msg.p1 = grant[ecd_pkg::ECD_SRC_DBG] ? dbg1 : 16'h0000;
    assign next_msg.p2 = grant[ecd_pkg::ECD_SRC_DBG] ? dbg2 : 16'h0000;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pend                  <= 5'h00;
            dbg2                  <= 16'h0000;
            diag_valid_o          <= 1'b0;
            diagnostic_text_log_o <= '0;
        end else begin
            pend         <= next_pend;
            diag_valid_o <= |pend;
            if (wr_dbg2) dbg2 <= wdata_i[15:0];
            if (|pend) diagnostic_text_log_o <= next_msg;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    property p_unf_set;
        g_ch[0].wrap_dn |=> underflow_o[0];
    endproperty
    a_unf_set: assert property (p_unf_set)
        else $error("underflow flag not set on wrap");

    property p_unf_hold;
        underflow_o[0] && !(count_i[0] < g_ch[0].th2) |=> underflow_o[0];
    endproperty
    a_unf_hold: assert property (p_unf_hold)
        else $error("underflow flag cleared above threshold");

    property p_ovf_set;
        g_ch[1].wrap_up |=> overflow_o[1];
    endproperty
    a_ovf_set: assert property (p_ovf_set)
        else $error("overflow flag not set on wrap");

    property p_ovf_clr;
        overflow_o[1] && !g_ch[1].wrap_up && count_i[1] > g_ch[1].th1
            |=> !overflow_o[1];
    endproperty
    a_ovf_clr: assert property (p_ovf_clr)
        else $error("overflow flag not cleared above one third");

    property p_no_se;
        !$past(cfg[0][ecd_pkg::ECD_CFG_DIFF]) |-> track_error_o[0] == 3'h0;
    endproperty
    a_no_se: assert property (p_no_se)
        else $error("fault flagged outside differential mode");

    property p_enable;
        track_error_o[0][0] |-> $past(cfg[0][0]);
    endproperty
    a_enable: assert property (p_enable)
        else $error("fault flagged on disabled track");

    property p_group;
        open_circuit_o == {|track_error_o[1], |track_error_o[0]}
        && data_invalid_flag_o == open_circuit_o;
    endproperty
    a_group: assert property (p_group)
        else $error("group or invalid flag disagrees with track errors");

    property p_led;
        track_error_o[0][0] |-> track_indicator_o[0][0]
                                == ecd_pkg::ECD_LED_RED;
    endproperty
    a_led: assert property (p_led)
        else $error("faulty track LED not red");

    property p_supply;
        supply_fail_o[1] |-> !supply_led_o[1];
    endproperty
    a_supply: assert property (p_supply)
        else $error("supply LED lit while supply missing");

    sequence s_dbg_req;
        wr_dbg2 ##0 (pend == 5'h00);
    endsequence
    sequence s_dbg_msg;
        diag_valid_o && diagnostic_text_log_o.text_id
            == ecd_pkg::ECD_ID_DEBUG;
    endsequence
    property p_debug;
        s_dbg_req |-> ##2 s_dbg_msg;
    endproperty
    a_debug: assert property (p_debug)
        else $error("debug message not logged two cycles after write");

    property p_trk_msg;
        ev_trk_a[0] |-> ##[1:6] (diag_valid_o
            && diagnostic_text_log_o.text_id == ecd_pkg::ECD_ID_TRACK_A);
    endproperty
    a_trk_msg: assert property (p_trk_msg)
        else $error("track A fault message missing");
endmodule

// ===== rtl/ecd_pkg.sv
// Purpose: Shared constants and types of the encoder counter diagnostics
// Assumes: 32-bit register port, two channels, three tracks per channel
// Notes:   Byte offsets; channel n registers sit at base + n * stride
package ecd_pkg;
    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] ECD_OFF_CFG    = 8'h00;
    localparam logic [7:0] ECD_OFF_LIMIT  = 8'h04;
    localparam logic [7:0] ECD_OFF_RESET  = 8'h08;
    localparam logic [7:0] ECD_OFF_STATUS = 8'h0C;
    localparam logic [7:0] ECD_CH_STRIDE  = 8'h10;
    localparam logic [7:0] ECD_OFF_DBG0   = 8'h20;
    localparam logic [7:0] ECD_OFF_DBG1   = 8'h24;
    localparam logic [7:0] ECD_OFF_DBG2   = 8'h28;
    // ****************************************************************
    // Fields and reset values
    // ****************************************************************
    localparam int ECD_CFG_DIFF = 3;
    localparam logic [3:0] ECD_CFG_RST = 4'hF;
    localparam int ECD_ST_UNF  = 0;
    localparam int ECD_ST_OVF  = 1;
    localparam int ECD_ST_OPEN = 2;
    localparam int ECD_ST_INV  = 3;
    localparam int ECD_ST_ERR  = 4;
    localparam int ECD_ST_SUP  = 7;
    localparam logic [1:0] ECD_LED_OFF   = 2'h0;
    localparam logic [1:0] ECD_LED_GREEN = 2'h1;
    localparam logic [1:0] ECD_LED_RED   = 2'h2;
    localparam int ECD_SYNC_STAGES = 3;
    // ****************************************************************
    // Diagnostic messages
    // ****************************************************************
    localparam logic [15:0] ECD_ID_TRACK_A = 16'h831B;
    localparam logic [15:0] ECD_ID_SUPPLY  = 16'h8303;
    localparam logic [15:0] ECD_ID_DEBUG   = 16'hFFFF;
    localparam int ECD_NSRC = 5;
    localparam int ECD_SRC_DBG = 4;
    typedef enum logic {ECD_T_ERROR, ECD_T_INFO} ecd_mtype_t;
    typedef struct packed {
        logic [15:0] text_id;
        ecd_mtype_t  mtype;
        logic        chan;
        logic [15:0] p0;
        logic [15:0] p1;
        logic [15:0] p2;
    } ecd_msg_t;
endpackage

// ===== rtl/ecd_sync.sv
// Purpose: Three-stage input synchroniser with agreement filter
// Assumes: Inputs come from pins outside the clock domain
// Notes:   Output moves only when stages two and three agree
`timescale 1ns/1ps
module ecd_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         sys_rst_i,
    // Data
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    // ****************************************************************
    // Stages
    // ****************************************************************
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    wire  [W-1:0] agree = ~(s2 ^ s3);
    wire  [W-1:0] next_q = (agree & s3) | (~agree & q_o);

    if (W < 1) begin : g_bad_w
        $error("ecd_sync width must be at least one");
    end

    // First stage feeds only the second
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s1  <= '0;
            s2  <= '0;
            s3  <= '0;
            q_o <= '0;
        end else begin
            s1  <= d_i;
            s2  <= s1;
            s3  <= s2;
            q_o <= next_q;
        end
    end
endmodule

// ===== testbench/ecd_encoder_model.sv
// Purpose: Encoder far side: track levels, pair faults, supply
// Assumes: Comparator decision is modelled at the pair, not in volts
// Notes:   A faulty pair floats, so its level wanders every cycle
`timescale 1ns/1ps
module ecd_encoder_model (
    // Clock
    input  wire logic            clk_i,
    // Stimulus
    input  wire logic [1:0][2:0] level_i,
    input  wire logic [1:0][2:0] break_i,
    input  wire logic [1:0][2:0] short_i,
    input  wire logic [1:0]      supply_on_i,
    // Pins
    output logic      [1:0][2:0] diff_low_o,
    output logic      [1:0][2:0] track_o,
    output logic      [1:0]      supply_ok_o
);
    // ****************************************************************
    // Pair behaviour
    // ****************************************************************
    logic [1:0][2:0] float_q = 6'h00;
    always @(posedge clk_i) begin
        float_q <= ~float_q;
    end
    // Broken and shorted pairs both collapse the differential voltage
    assign diff_low_o  = break_i | short_i;
    assign track_o     = (level_i & ~diff_low_o) | (float_q & diff_low_o);
    assign supply_ok_o = supply_on_i;
endmodule

// ===== testbench/encoder_counter_diagnostics_tb.sv
// Purpose: Self-checking bench of the encoder counter diagnostics
// Assumes: Default widths, two channels, register port as in the notes
// Notes:   Waits on pins cover the three-stage input filter
`timescale 1ns/1ps
module encoder_counter_diagnostics_tb;
    logic              clk_i = 1'b0;
    logic              sys_rst_i = 1'b1;
    logic [7:0]        addr_i = 8'h00;
    logic [31:0]       wdata_i = 32'h0;
    logic              wr_i = 1'b0;
    logic              rd_i = 1'b0;
    logic [31:0]       rdata_o;
    logic [1:0][31:0]  count_i = 64'h0;
    logic [1:0][2:0]   level_i = 6'h00;
    logic [1:0][2:0]   brk = 6'h00;
    logic [1:0][2:0]   shrt = 6'h00;
    logic [1:0]        supply_on = 2'h3;
    logic [1:0][2:0]   diff_low;
    logic [1:0][2:0]   track;
    logic [1:0]        supply_ok;
    logic [1:0]        underflow_o;
    logic [1:0]        overflow_o;
    logic [1:0]        open_circuit_o;
    logic [1:0]        data_invalid_flag_o;
    logic [1:0][2:0]   track_error_o;
    logic [1:0]        supply_fail_o;
    logic [1:0][2:0][1:0] track_indicator_o;
    logic [1:0]        supply_led_o;
    logic              diag_valid_o;
    ecd_pkg::ecd_msg_t diag_msg;
    ecd_pkg::ecd_msg_t last_msg;
    int                mismatches = 0;
    int                samples_checked = 0;
    int                msg_cnt = 0;
    int                n;
    logic [7:0]        st1;
    // ****************************************************************
    // Instances
    // ****************************************************************
    ecd_encoder_model enc (.clk_i(clk_i), .level_i(level_i), .break_i(brk),
        .short_i(shrt), .supply_on_i(supply_on), .diff_low_o(diff_low),
        .track_o(track), .supply_ok_o(supply_ok));
    ecd_diag dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .count_i(count_i), .diff_low_i(diff_low), .track_i(track),
        .supply_ok_i(supply_ok), .underflow_o(underflow_o),
        .overflow_o(overflow_o), .open_circuit_o(open_circuit_o),
        .data_invalid_flag_o(data_invalid_flag_o),
        .track_error_o(track_error_o), .supply_fail_o(supply_fail_o),
        .track_indicator_o(track_indicator_o), .supply_led_o(supply_led_o),
        .diag_valid_o(diag_valid_o), .diagnostic_text_log_o(diag_msg));
    // ****************************************************************
    // Tasks
    // ****************************************************************
    always #10 clk_i = ~clk_i;
    // Message pulse lasts one cycle, so it is caught on every edge
    always @(posedge clk_i) begin
        if (diag_valid_o === 1'b1) begin
            msg_cnt  <= msg_cnt + 1;
            last_msg <= diag_msg;
        end
    end
    task automatic settle(input int c);
        repeat (c) @(posedge clk_i);
        #1;
    endtask
    task automatic check(input logic [31:0] got, exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what,
                     got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask
    task automatic check_reg(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        #1;
        check(rdata_o, exp, "register read");
    endtask
    task automatic check_msg(input int cnt, input logic [15:0] id,
                             input ecd_pkg::ecd_mtype_t ty);
        check(msg_cnt, cnt, "message count");
        check(last_msg.text_id, id, "text id");
        check(last_msg.mtype, ty, "message type");
    endtask
    task automatic set_cnt(input int ch, input logic [31:0] v);
        @(posedge clk_i);
        count_i[ch] <= v;
        settle(2);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Whole sequence needs well under a thousand cycles
    initial begin
        #200000;
        mismatches++;
        $display("mismatch at %0t: watchdog expired", $time);
        tally_and_finish();
    end
    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        st1 = ecd_pkg::ECD_OFF_STATUS + ecd_pkg::ECD_CH_STRIDE;
        repeat (6) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        settle(10);
        check_reg(ecd_pkg::ECD_OFF_CFG, 32'hF);
        check_reg(ecd_pkg::ECD_OFF_LIMIT, 32'hFFFFFFFF);
        check_reg(ecd_pkg::ECD_OFF_RESET, 32'h0);
        check_reg(8'h30, 32'h0);
        check({underflow_o, overflow_o, open_circuit_o}, 32'h0, "rst");
        $display("test reset done");
        set_cnt(0, 32'hFFFFFFFF);
        check(underflow_o, 2'h1, "underflow set");
        set_cnt(0, 32'hAAAAAAAA);
        check(underflow_o, 2'h1, "underflow held");
        set_cnt(0, 32'hAAAAAAA9);
        check(underflow_o, 2'h0, "underflow clear");
        set_cnt(1, 32'hFFFFFFFF);
        set_cnt(1, 32'h0);
        check(overflow_o, 2'h2, "overflow set");
        set_cnt(1, 32'h55555555);
        check(overflow_o, 2'h2, "overflow held");
        set_cnt(1, 32'h55555556);
        check(overflow_o, 2'h0, "overflow clear");
        wr(ecd_pkg::ECD_OFF_LIMIT, 32'hFF);
        check_reg(ecd_pkg::ECD_OFF_LIMIT, 32'hFF);
        set_cnt(0, 32'h0);
        set_cnt(0, 32'hFF);
        check(underflow_o, 2'h1, "underflow at limit");
        set_cnt(0, 32'hA9);
        check(underflow_o, 2'h0, "underflow clear at limit");
        wr(ecd_pkg::ECD_OFF_RESET, 32'h10);
        check_reg(ecd_pkg::ECD_OFF_RESET, 32'h10);
        $display("test counter wrap done");
        n = msg_cnt;
        @(posedge clk_i);
        level_i[0] <= 3'h2;
        brk[0]     <= 3'h1;
        settle(9);
        check(track_error_o[0], 3'h1, "error A");
        check(open_circuit_o, 2'h1, "group open");
        check(data_invalid_flag_o, 2'h1, "invalid");
        check(track_indicator_o[0], 6'h06, "leds");
        check_msg(n + 1, ecd_pkg::ECD_ID_TRACK_A, ecd_pkg::ECD_T_ERROR);
        check(last_msg.chan, 1'b0, "channel");
        check_reg(ecd_pkg::ECD_OFF_STATUS, 32'h1C);
        @(posedge clk_i);
        brk[0]  <= 3'h0;
        shrt[1] <= 3'h1;
        settle(9);
        check(track_error_o[1], 3'h1, "short A");
        check(open_circuit_o, 2'h2, "group open ch1");
        check_msg(n + 2, ecd_pkg::ECD_ID_TRACK_A, ecd_pkg::ECD_T_ERROR);
        check(last_msg.chan, 1'b1, "channel");
        $display("test open circuit done");
        wr(ecd_pkg::ECD_OFF_CFG, 32'hE);
        @(posedge clk_i);
        shrt[1] <= 3'h0;
        brk[0]  <= 3'h1;
        settle(9);
        check(track_error_o[0], 3'h0, "A disabled");
        check(open_circuit_o, 2'h0, "open disabled");
        wr(ecd_pkg::ECD_OFF_CFG, 32'h7);
        @(posedge clk_i);
        brk[0] <= 3'h2;
        settle(9);
        check(track_error_o[0], 3'h0, "single ended");
        n = msg_cnt;
        wr(ecd_pkg::ECD_OFF_CFG, 32'hF);
        settle(3);
        check(track_error_o[0], 3'h2, "error B");
        check(open_circuit_o, 2'h1, "group B");
        check(msg_cnt, n, "no message for B");
        $display("test enables done");
        @(posedge clk_i);
        brk[0]    <= 3'h0;
        supply_on <= 2'h1;
        settle(9);
        check(supply_fail_o, 2'h2, "supply fail");
        check(supply_led_o, 2'h1, "supply led");
        check_msg(n + 1, ecd_pkg::ECD_ID_SUPPLY, ecd_pkg::ECD_T_ERROR);
        check_reg(st1, 32'h80);
        @(posedge clk_i);
        supply_on <= 2'h3;
        settle(9);
        check(supply_fail_o, 2'h0, "supply back");
        $display("test supply done");
        n = msg_cnt;
        wr(ecd_pkg::ECD_OFF_DBG0, 32'h1234);
        wr(ecd_pkg::ECD_OFF_DBG1, 32'h5678);
        wr(ecd_pkg::ECD_OFF_DBG2, 32'h9ABC);
        settle(3);
        check_msg(n + 1, ecd_pkg::ECD_ID_DEBUG, ecd_pkg::ECD_T_INFO);
        check({last_msg.p0, last_msg.p1}, 32'h12345678, "p0 p1");
        check(last_msg.p2, 16'h9ABC, "p2");
        $display("test debug message done");
        tally_and_finish();
    end
endmodule
